//--- adc_coding_chk.sv
// assertion checker for the output coding block
`timescale 1ns/100ps

module adc_coding_chk (
    // clock and reset
    input wire        core_clk,
    input wire        reset_n,
    // inputs watched
    input wire [13:0] adc_code,
    input wire        over_range_pos,
    input wire        over_range_neg,
    input wire [3:0]  test_mode,
    input wire        offset_binary_sel,
    input wire        word_len_12,
    input wire        lsb_first,
    // outputs watched
    input wire [15:0] out_word_reg,
    input wire        word_strobe_reg,
    input wire        drive_enable_reg,
    input wire        power_down_reg,
    input wire        test_active_reg
);
    reg  [3:0] mode_d1_reg;
    reg  [3:0] mode_d2_reg;
    reg  [1:0] cfg_d1_reg;
    wire       new16 = word_strobe_reg && mode_d1_reg == mode_d2_reg && cfg_d1_reg == 2'b00;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_d1_reg <= 4'h0;
            mode_d2_reg <= 4'h0;
            cfg_d1_reg  <= 2'b00;
        end else begin
            mode_d1_reg <= test_mode;
            mode_d2_reg <= mode_d1_reg;
            cfg_d1_reg  <= {word_len_12, lsb_first};
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_STROBE_PULSE: assert property (word_strobe_reg |=> !word_strobe_reg [*5])
        else $error("strobe repeated too soon");
    AST_PD_DRIVE: assert property (power_down_reg |-> !drive_enable_reg)
        else $error("drivers on in power down");
    AST_PD_QUIET: assert property (power_down_reg && $past(power_down_reg) |-> !word_strobe_reg)
        else $error("strobe in power down");
    AST_PD_ZERO: assert property (power_down_reg && $past(power_down_reg) |-> out_word_reg == 16'h0000)
        else $error("word not zero in power down");
    AST_TEST_FLAG: assert property (1'b1 |=> test_active_reg == ($past(test_mode) != 4'h0))
        else $error("test flag wrong");
    AST_CHECKER: assert property (new16 && mode_d1_reg == 4'h4 |-> out_word_reg inside {16'hAAA8, 16'h5554})
        else $error("checkerboard word wrong");
    AST_SYNC: assert property (new16 && mode_d1_reg == 4'hA |-> out_word_reg == 16'h01FC)
        else $error("sync word wrong");
    AST_MIXED: assert property (new16 && mode_d1_reg == 4'hC |-> out_word_reg == 16'hA19C)
        else $error("mixed word wrong");
    AST_PASS: assert property (new16 && mode_d1_reg == 4'h0 && !$past(over_range_pos) && !$past(over_range_neg)
        |-> out_word_reg == {$past(adc_code) ^ {!$past(offset_binary_sel), 13'h0000}, 2'b00})
        else $error("sample word wrong");

    cover property (word_strobe_reg && mode_d1_reg == 4'h6);
    cover property (power_down_reg);
    cover property (new16 && mode_d1_reg == 4'h8);
endmodule // adc_coding_chk

bind adc_output_coding_test_pattern_gen adc_coding_chk chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .adc_code(adc_code), .over_range_pos(over_range_pos),
    .over_range_neg(over_range_neg), .test_mode(test_mode), .offset_binary_sel(offset_binary_sel),
    .word_len_12(word_len_12), .lsb_first(lsb_first), .out_word_reg(out_word_reg),
    .word_strobe_reg(word_strobe_reg), .drive_enable_reg(drive_enable_reg),
    .power_down_reg(power_down_reg), .test_active_reg(test_active_reg)
);

//--- adc_output_coding_test_pattern_gen.v
// output word coding and test pattern generator for one converter channel
`timescale 1ns/100ps
`include "adc_test_regs.vh"

module adc_output_coding_test_pattern_gen #(
    parameter SAMPLE_W = 14,
    parameter WORD_W   = 16
) (
    // clock and reset
    input  wire                core_clk,
    input  wire                reset_n,
    // pins from outside the clock domain
    input  wire                sample_clk,
    input  wire                serial_io_or_sleep_pin,
    input  wire                port_select_n,
    // converter core sample
    input  wire [SAMPLE_W-1:0] adc_code,
    input  wire                over_range_pos,
    input  wire                over_range_neg,
    // configuration
    input  wire [3:0]          test_mode,
    input  wire                offset_binary_sel,
    input  wire                word_len_12,
    input  wire                lsb_first,
    input  wire [WORD_W-1:0]   user_word1,
    input  wire [WORD_W-1:0]   user_word2,
    input  wire                long_prbs_reset,
    input  wire                short_prbs_reset,
    input  wire                soft_power_down,
    // output words
    output reg  [WORD_W-1:0]   out_word_reg,
    output reg                 word_strobe_reg,
    output reg                 word_phase_reg,
    output reg                 drive_enable_reg,
    // status
    output reg                 power_down_reg,
    output reg                 test_active_reg
);

    // ----------------------------------------
    // local helpers
    // ----------------------------------------
    // twelve or sixteen bit form
    function [15:0] pick;
        input        w12;
        input [15:0] p16;
        input [11:0] p12;
        begin
            pick = w12 ? {p12, 4'h0} : p16;
        end
    endfunction

    function formatted;
        input [3:0] mode;
        begin
            case (mode)
                `TM_OFF, `TM_MIDSCALE, `TM_POS_FS, `TM_NEG_FS,
                `TM_LONG_PRBS, `TM_SHORT_PRBS: formatted = 1'b1;
                default: formatted = 1'b0;
            endcase
        end
    endfunction

    function two_word;
        input [3:0] mode;
        begin
            case (mode)
                `TM_CHECKER, `TM_WORD_TOGGLE, `TM_USER: two_word = 1'b1;
                default: two_word = 1'b0;
            endcase
        end
    endfunction

    function [15:0] reverse_word;
        input [15:0] w;
        input        w12;
        integer i;
        begin
            reverse_word = 16'h0000;
            for (i = 0; i < 16; i = i + 1) begin
                reverse_word[15-i] = w[i];
            end
            if (w12) begin
                reverse_word = {reverse_word[11:0], 4'h0};
            end
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire [2:0] pin_lvl;
    wire       sample_lvl;
    wire       sleep_lvl;
    wire       port_off_lvl;

    sync_3ff #(
        .WIDTH     (3),
        .RESET_VAL (0)
    ) u_pin_sync (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .pin_in    ({port_select_n, serial_io_or_sleep_pin, sample_clk}),
        .level_out (pin_lvl)
    );

    assign sample_lvl   = pin_lvl[0];
    assign sleep_lvl    = pin_lvl[1];
    assign port_off_lvl = pin_lvl[2];

    // ----------------------------------------
    // frame tick and power down
    // ----------------------------------------
    reg  sample_prev_reg;
    reg  [3:0] mode_prev_reg;
    wire frame_tick;
    wire pd_active;
    wire run_tick;
    wire mode_change;
    wire word_load;

    assign frame_tick  = sample_lvl & ~sample_prev_reg;
    // pin controls power when port unused
    assign pd_active   = port_off_lvl ? sleep_lvl : soft_power_down;
    assign run_tick    = frame_tick & ~pd_active;
    assign mode_change = (test_mode != mode_prev_reg);
    assign word_load   = run_tick & ~mode_change;

    // ----------------------------------------
    // sequence generators
    // ----------------------------------------
    wire [13:0] short_word;
    wire [13:0] long_word;
    wire        short_adv;
    wire        long_adv;

    assign short_adv = run_tick & (test_mode == `TM_SHORT_PRBS);
    assign long_adv  = run_tick & (test_mode == `TM_LONG_PRBS);

    prbs_gen #(
        .STAGES (`SHORT_STAGES),
        .TAP    (`SHORT_TAP),
        .WORD   (`SAMPLE_BITS),
        .INVERT (0)
    ) u_short_prbs (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .restart  (short_prbs_reset),
        .advance  (short_adv),
        .word     (short_word)
    );

    prbs_gen #(
        .STAGES (`LONG_STAGES),
        .TAP    (`LONG_TAP),
        .WORD   (`SAMPLE_BITS),
        .INVERT (0)
    ) u_long_prbs (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .restart  (long_prbs_reset),
        .advance  (long_adv),
        .word     (long_word)
    );

    // ----------------------------------------
    // sample coding
    // ----------------------------------------
    reg [13:0] clamped;
    reg [15:0] sample_word;

    always @* begin
        if (over_range_pos) begin
            clamped = `SAMPLE_MAX;
        end else if (over_range_neg) begin
            clamped = `SAMPLE_MIN;
        end else begin
            clamped = adc_code;
        end
        sample_word = pick(word_len_12, {clamped, 2'b00}, clamped[13:2]);
    end

    // ----------------------------------------
    // pattern selection
    // ----------------------------------------
    reg  [15:0] raw_word;
    reg  [15:0] coded_word;
    reg  [15:0] next_word;
    wire        phase_b;

    assign phase_b = word_phase_reg & two_word(test_mode);

    always @* begin
        raw_word = sample_word;
        case (test_mode)
            `TM_OFF: begin
                raw_word = sample_word;
            end
            `TM_MIDSCALE: begin
                raw_word = pick(word_len_12, `P16_MID, `P12_MID);
            end
            `TM_POS_FS: begin
                raw_word = pick(word_len_12, `P16_POS_FS, `P12_POS_FS);
            end
            `TM_NEG_FS: begin
                raw_word = pick(word_len_12, `P16_NEG_FS, `P12_NEG_FS);
            end
            `TM_CHECKER: begin
                raw_word = phase_b ? pick(word_len_12, `P16_CHECK_B, `P12_CHECK_B)
                                   : pick(word_len_12, `P16_CHECK_A, `P12_CHECK_A);
            end
            `TM_LONG_PRBS: begin
                raw_word = {long_word, 2'b00};
            end
            `TM_SHORT_PRBS: begin
                raw_word = {short_word, 2'b00};
            end
            `TM_WORD_TOGGLE: begin
                raw_word = phase_b ? pick(word_len_12, `P16_NEG_FS, `P12_NEG_FS)
                                   : pick(word_len_12, `P16_POS_FS, `P12_POS_FS);
            end
            `TM_USER: begin
                raw_word = phase_b ? pick(word_len_12, user_word2, user_word2[15:4])
                                   : pick(word_len_12, user_word1, user_word1[15:4]);
            end
            `TM_BIT_TOGGLE: begin
                raw_word = pick(word_len_12, `P16_CHECK_A, `P12_CHECK_A);
            end
            `TM_SYNC: begin
                raw_word = pick(word_len_12, `P16_SYNC, `P12_SYNC);
            end
            `TM_ONE_BIT: begin
                raw_word = pick(word_len_12, `P16_MID, `P12_MID);
            end
            `TM_MIXED: begin
                raw_word = pick(word_len_12, `P16_MIXED, `P12_MIXED);
            end
            // codes 13 to 15 pass the sample word, msb never inverted
            default: begin
                raw_word = sample_word;
            end
        endcase
        coded_word = raw_word;
        if (formatted(test_mode) && !offset_binary_sel) begin
            coded_word[15] = ~raw_word[15];
        end
        next_word = lsb_first ? reverse_word(coded_word, word_len_12) : coded_word;
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_prev_reg  <= 1'b0;
            mode_prev_reg    <= `TM_OFF;
            out_word_reg     <= 16'h0000;
            word_strobe_reg  <= 1'b0;
            word_phase_reg   <= 1'b0;
        end else begin
            sample_prev_reg  <= sample_lvl;
            mode_prev_reg    <= test_mode;
            // strobe only with a new word
            word_strobe_reg  <= word_load;
            if (pd_active) begin
                out_word_reg   <= 16'h0000;
                word_phase_reg <= 1'b0;
            end else if (mode_change) begin
                word_phase_reg <= 1'b0;
            end else if (run_tick) begin
                out_word_reg   <= next_word;
                word_phase_reg <= two_word(test_mode) & ~word_phase_reg;
            end
        end
    end

    // ----------------------------------------
    // status registers
    // ----------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_down_reg   <= 1'b0;
            drive_enable_reg <= 1'b0;
            test_active_reg  <= 1'b0;
        end else begin
            power_down_reg   <= pd_active;
            drive_enable_reg <= ~pd_active;
            test_active_reg  <= (test_mode != `TM_OFF);
        end
    end

endmodule // adc_output_coding_test_pattern_gen

//--- adc_output_coding_test_pattern_gen_tb_top.sv
// self-checking bench for the output coding block
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module adc_output_coding_test_pattern_gen_tb_top;
    reg         core_clk = 1'b0, reset_n = 1'b0, sample_clk = 1'b0, sleep_pin = 1'b0, psel_n = 1'b1;
    reg  [13:0] adc_code = 14'h0000;
    reg  [3:0]  test_mode = 4'h0;
    reg         orp = 1'b0, orn = 1'b0, ob = 1'b0, w12 = 1'b0, lsbf = 1'b0, lrst = 1'b0, srst = 1'b0, spd = 1'b0;
    reg  [15:0] uw1 = 16'h1234, uw2 = 16'hFEDC;
    wire [15:0] out_word, rx_word;
    wire [31:0] rx_count;
    wire        strobe, phase, drv_en, pd, tact;
    integer     n_mismatch = 0, total_checks = 0;

    always #5 core_clk = ~core_clk;
    always #40 sample_clk = ~sample_clk;

    adc_output_coding_test_pattern_gen dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .sample_clk(sample_clk), .serial_io_or_sleep_pin(sleep_pin),
        .port_select_n(psel_n), .adc_code(adc_code), .over_range_pos(orp), .over_range_neg(orn),
        .test_mode(test_mode), .offset_binary_sel(ob), .word_len_12(w12), .lsb_first(lsbf),
        .user_word1(uw1), .user_word2(uw2), .long_prbs_reset(lrst), .short_prbs_reset(srst),
        .soft_power_down(spd), .out_word_reg(out_word), .word_strobe_reg(strobe), .word_phase_reg(phase),
        .drive_enable_reg(drv_en), .power_down_reg(pd), .test_active_reg(tact)
    );

    word_rx_model rx_u (
        .core_clk(core_clk), .reset_n(reset_n), .out_word_reg(out_word), .word_strobe_reg(strobe),
        .drive_enable_reg(drv_en), .rx_word_reg(rx_word), .rx_count_reg(rx_count)
    );

    task tally_and_finish;
        begin
            $display("mismatches=%0d checks=%0d", n_mismatch, total_checks);
            if (n_mismatch == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    task tick;
        begin
            @(posedge core_clk);
            #1;
        end
    endtask

    // ----------------------------------------
    // word capture
    // ----------------------------------------
    task get_word(output [15:0] w);
        reg [31:0] c0;
        integer    i;
        begin
            c0 = rx_count;
            i = 0;
            while (rx_count === c0 && i < 40) begin
                tick;
                i = i + 1;
            end
            if (i == 40) begin
                n_mismatch++;
                tally_and_finish;
            end else begin
                w = rx_word;
            end
        end
    endtask

    task skip_get(output [15:0] w);
        reg [15:0] d;
        begin
            get_word(d);
            get_word(w);
        end
    endtask

    function [15:0] fixed_exp(input [3:0] m, input o, input t);
        begin
            case (m)
                4'h1: fixed_exp = 16'h8000;
                4'h2: fixed_exp = t ? 16'hFFF0 : 16'hFFFC;
                4'h3: fixed_exp = 16'h0000;
                4'h9: fixed_exp = t ? 16'hAAA0 : 16'hAAA8;
                4'hA: fixed_exp = t ? 16'h03F0 : 16'h01FC;
                4'hB: fixed_exp = 16'h8000;
                default: fixed_exp = t ? 16'hA330 : 16'hA19C;
            endcase
            if (m < 4'h4 && !o) fixed_exp[15] = ~fixed_exp[15];
        end
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_samples;
        reg [55:0] cl;
        reg [15:0] w, e, r;
        reg [13:0] c;
        integer    k, j;
        begin
            cl = {14'h1235, 14'h3FFF, 14'h2000, 14'h0000};
            for (k = 0; k < 8; k = k + 1) begin
                adc_code = cl[14*(k%4) +: 14];
                ob = k[2];
                orp = (k == 4);
                orn = (k == 6);
                lsbf = (k == 7);
                c = orp ? 14'h3FFF : orn ? 14'h0000 : adc_code;
                e = {c ^ {~ob, 13'h0000}, 2'b00};
                for (j = 0; j < 16; j = j + 1) begin
                    r[15-j] = e[j];
                end
                e = lsbf ? r : e;
                skip_get(w);
                `CHK(w, e)
            end
            lsbf = 1'b0;
        end
    endtask

    task t_fixed;
        reg [27:0] ml;
        reg [15:0] w;
        integer    k, f;
        begin
            ml = 28'hCBA9321;
            adc_code = 14'h1555;
            for (k = 0; k < 7; k = k + 1)
                for (f = 0; f < 4; f = f + 1) begin
                    test_mode = ml[4*k +: 4];
                    {ob, w12} = f[1:0];
                    skip_get(w);
                    `CHK(w, fixed_exp(test_mode, ob, w12))
                end
            w12 = 1'b0;
        end
    endtask

    task t_pairs;
        reg [15:0] a, b, c, w1, w2;
        integer    k;
        begin
            ob = 1'b0;
            for (k = 0; k < 3; k = k + 1) begin
                test_mode = (k == 0) ? 4'h4 : (k == 1) ? 4'h7 : 4'h8;
                w1 = (k == 0) ? 16'hAAA8 : (k == 1) ? 16'hFFFC : uw1;
                w2 = (k == 0) ? 16'h5554 : (k == 1) ? 16'h0000 : uw2;
                skip_get(a);
                `CHK({tact, phase}, 2'b10)
                get_word(b);
                get_word(c);
                `CHK({a, b, c}, {w2, w1, w2})
            end
        end
    endtask

    task t_prbs(input [3:0] m, input t, input [63:0] ex);
        reg [15:0] w;
        integer    k;
        begin
            ob = 1'b0;
            w12 = t;
            test_mode = m;
            srst = 1'b1;
            lrst = 1'b1;
            skip_get(w);
            srst = 1'b0;
            lrst = 1'b0;
            for (k = 3; k >= 0; k = k - 1) begin
                get_word(w);
                `CHK(w, ex[16*k +: 16])
            end
            w12 = 1'b0;
        end
    endtask

    task t_power;
        reg [31:0] c0;
        reg [15:0] w;
        begin
            test_mode = 4'h2;
            sleep_pin = 1'b1;
            repeat (8) tick;
            c0 = rx_count;
            `CHK({pd, drv_en, out_word}, {2'b10, 16'h0000})
            repeat (24) tick;
            `CHK(rx_count, c0)
            psel_n = 1'b0;
            repeat (8) tick;
            `CHK({pd, drv_en}, 2'b01)
            spd = 1'b1;
            repeat (8) tick;
            `CHK(pd, 1'b1)
            spd = 1'b0;
            psel_n = 1'b1;
            sleep_pin = 1'b0;
            skip_get(w);
            `CHK(w, 16'h7FFC)
        end
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        #1 reset_n = 1'b1;
        tick;
        `CHK({pd, drv_en, tact}, 3'b010)
        t_samples;
        t_fixed;
        t_pairs;
        t_prbs(4'h6, 1'b0, 64'h7F80_77C4_F320_A538);
        t_prbs(4'h6, 1'b1, 64'h7F80_77C4_F320_A538);
        t_prbs(4'h5, 1'b1, 64'h7FFC_7F80_8004_7000);
        t_power;
        tally_and_finish;
    end
endmodule // adc_output_coding_test_pattern_gen_tb_top

//--- adc_test_regs.vh
// constants for output coding and test pattern generation
`ifndef ADC_TEST_REGS_VH
`define ADC_TEST_REGS_VH

// ----------------------------------------
// test mode codes
// ----------------------------------------
`define TM_OFF          4'h0
`define TM_MIDSCALE     4'h1
`define TM_POS_FS       4'h2
`define TM_NEG_FS       4'h3
`define TM_CHECKER      4'h4
`define TM_LONG_PRBS    4'h5
`define TM_SHORT_PRBS   4'h6
`define TM_WORD_TOGGLE  4'h7
`define TM_USER         4'h8
`define TM_BIT_TOGGLE   4'h9
`define TM_SYNC         4'hA
`define TM_ONE_BIT      4'hB
`define TM_MIXED        4'hC

// ----------------------------------------
// fixed words, 16-bit and 12-bit forms
// ----------------------------------------
`define P16_MID         16'h8000
`define P12_MID         12'h800
`define P16_POS_FS      16'hFFFC
`define P12_POS_FS      12'hFFF
`define P16_NEG_FS      16'h0000
`define P12_NEG_FS      12'h000
`define P16_CHECK_A     16'hAAA8
`define P12_CHECK_A     12'hAAA
`define P16_CHECK_B     16'h5554
`define P12_CHECK_B     12'h555
`define P16_SYNC        16'h01FC
`define P12_SYNC        12'h03F
`define P16_MIXED       16'hA19C
`define P12_MIXED       12'hA33

// ----------------------------------------
// sample and sequence sizes
// ----------------------------------------
`define SAMPLE_BITS     14
`define SAMPLE_MAX      14'h3FFF
`define SAMPLE_MIN      14'h0000
`define SHORT_STAGES    9
`define SHORT_TAP       5
`define LONG_STAGES     23
`define LONG_TAP        18

`endif

//--- prbs_gen.v
// fibonacci sequence generator, one word of bits per advance
`timescale 1ns/100ps

module prbs_gen #(
    parameter STAGES = 9,
    parameter TAP    = 5,
    parameter WORD   = 14,
    parameter INVERT = 0
) (
    // clock and reset
    input  wire            core_clk,
    input  wire            reset_n,
    // control
    input  wire            restart,
    input  wire            advance,
    // next word, first bit in msb
    output wire [WORD-1:0] word
);

    reg [STAGES-1:0] state_reg;
    reg [STAGES-1:0] state_next;
    reg [WORD-1:0]   word_bits;

    // ----------------------------------------
    // unrolled word of sequence steps
    // ----------------------------------------
    always @* begin : step
        integer i;
        reg [STAGES-1:0] s;
        reg fb;
        i = 0;
        s = state_reg;
        fb = 1'b0;
        word_bits = {WORD{1'b0}};
        for (i = 0; i < WORD; i = i + 1) begin
            word_bits[WORD-1-i] = s[STAGES-1];
            fb = s[STAGES-1] ^ s[TAP-1];
            s = {s[STAGES-2:0], fb};
        end
        state_next = s;
    end

    assign word = (INVERT != 0) ? ~word_bits : word_bits;

    // ----------------------------------------
    // state, seeded all ones
    // ----------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= {STAGES{1'b1}};
        end else if (restart) begin
            state_reg <= {STAGES{1'b1}};
        end else if (advance) begin
            state_reg <= state_next;
        end
    end

endmodule // prbs_gen

//--- sync_3ff.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module sync_3ff #(
    parameter WIDTH     = 1,
    parameter RESET_VAL = 0
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             reset_n,
    // pins in, filtered levels out
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out
);

    localparam [WIDTH-1:0] INIT = RESET_VAL[WIDTH-1:0];

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    reg [WIDTH-1:0] lvl_reg;
    wire [WIDTH-1:0] agree;

    assign agree     = ~(s2_reg ^ s3_reg);
    assign level_out = lvl_reg;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg  <= INIT;
            s2_reg  <= INIT;
            s3_reg  <= INIT;
            lvl_reg <= INIT;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= (agree & s3_reg) | (~agree & lvl_reg);
        end
    end

endmodule // sync_3ff

//--- word_rx_model.sv
// far-end receiver model capturing output words
`timescale 1ns/100ps

module word_rx_model (
    // clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // words from the block
    input  wire [15:0] out_word_reg,
    input  wire        word_strobe_reg,
    input  wire        drive_enable_reg,
    // captured words
    output reg  [15:0] rx_word_reg,
    output reg  [31:0] rx_count_reg
);
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_word_reg  <= 16'h0000;
            rx_count_reg <= 32'h0000_0000;
        end else if (word_strobe_reg && drive_enable_reg) begin
            rx_word_reg  <= out_word_reg;
            rx_count_reg <= rx_count_reg + 32'h0000_0001;
        end
    end
endmodule // word_rx_model
